// File: rgmii_ddr_sdr_bridge.sv
// Bridge from a double-rate four-bit PHY link to single-rate byte ports.
// Summary of operation
// - Link follows reduced gigabit interface conventions.
// - Enable hands the pins from GPIO to bridge.
// - Enabled bridge owns its ports and pins.
// - Four-bit double rate becomes eight-bit single rate.
// - Four data bits and one control each way.
// - Gigabit link clocks run at 125 MHz.
// - Bridge makes transmit clock, optional edge delay.
// - Separate clock strobes for transmit and receive.
// - Speed tracking updates on valid falling edge.
// - Management lines are open-drain single bits.
`default_nettype none
module rgmii_ddr_sdr_bridge (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic ENABLE,
  input wire logic [rgmii_bridge_pkg::DIV_W-1:0] TX_CLK_HALF,
  input wire logic TX_CLK_SKEW,
  input wire logic [rgmii_bridge_pkg::WORD_W-1:0] TX_DATA,
  input wire logic TX_EN,
  input wire logic TX_ER,
  output logic TX_TAKE,
  output logic [rgmii_bridge_pkg::WORD_W-1:0] RX_DATA,
  output logic RX_DV,
  output logic RX_ER,
  output logic RX_STROBE,
  output var rgmii_bridge_pkg::speed_e LINK_SPEED,
  input wire logic [rgmii_bridge_pkg::GPIO_W-1:0] GPIO_OUT,
  input wire logic [rgmii_bridge_pkg::GPIO_W-1:0] GPIO_OE,
  output logic [rgmii_bridge_pkg::GPIO_W-1:0] GPIO_IN,
  output logic [rgmii_bridge_pkg::NIBBLE_W-1:0] TXD_O,
  output logic [rgmii_bridge_pkg::NIBBLE_W-1:0] TXD_OE,
  output logic TX_CTL_O,
  output logic TX_CTL_OE,
  output logic TX_CLK_O,
  output logic TX_CLK_OE,
  input wire logic [rgmii_bridge_pkg::NIBBLE_W-1:0] RXD,
  input wire logic RX_CTL,
  input wire logic RX_CLK,
  input wire logic SMI_CLK_LOW,
  input wire logic SMI_DATA_LOW,
  output logic SMI_DATA_IN,
  output logic MDC_O,
  output logic MDC_OE,
  output logic MDIO_O,
  output logic MDIO_OE,
  input wire logic MDIO_I,
  input wire logic PHY_RELEASE,
  output logic PHY_RST_N_O
);
  import rgmii_bridge_pkg::*;

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  logic rst_s1, rst_n;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Clock, data, control and management input all pass two flip-flops with equal latency.
  localparam int SYNC_W = NIBBLE_W + 3;
  logic [SYNC_W-1:0] in_s1, in_s2;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      in_s1 <= {MDIO_I, RX_CLK, RX_CTL, RXD};
      in_s2 <= in_s1;
    end
  end
  wire [NIBBLE_W-1:0] rxd_s2 = in_s2[NIBBLE_W-1:0];
  wire ctl_s2 = in_s2[NIBBLE_W];
  wire rxc_s2 = in_s2[NIBBLE_W+1];
  wire mdio_s2 = in_s2[NIBBLE_W+2];

  // ****************************************************************
  // Ownership of pins and ports
  // ****************************************************************
  wire en = ENABLE & rst_n;

  // ****************************************************************
  // Receive path: rising edge gives low nibble and valid
  // ****************************************************************
  logic rxc_d;
  logic [NIBBLE_W-1:0] lo_nib;
  logic ctl_r;
  wire rx_rise = rxc_s2 & ~rxc_d;
  wire rx_fall = ~rxc_s2 & rxc_d;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rxc_d <= 1'b0;
      lo_nib <= '0;
      ctl_r <= 1'b0;
    end else begin
      rxc_d <= rxc_s2;
      if (en && rx_rise) begin
        lo_nib <= rxd_s2;
        ctl_r <= ctl_s2;
      end
    end
  end

  // The falling edge completes the byte and is the receive clock strobe.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RX_DATA <= '0;
      RX_DV <= 1'b0;
      RX_ER <= 1'b0;
      RX_STROBE <= 1'b0;
    end else begin
      RX_STROBE <= en & rx_fall;
      if (!en) begin
        RX_DV <= 1'b0;
        RX_ER <= 1'b0;
      end else if (rx_fall) begin
        RX_DATA <= {rxd_s2, lo_nib};
        RX_DV <= ctl_r;
        RX_ER <= ctl_r ^ ctl_s2;
      end
    end
  end

  // ****************************************************************
  // Speed tracking, updated when valid falls
  // ****************************************************************
  logic [PERIOD_W-1:0] period_cnt, period;
  logic dv_d;
  wire dv_fell = dv_d & ~RX_DV;
  wire speed_e next_speed = (period <= PERIOD_W'(GIGA_MAX_CYCLES)) ? SPEED_1000M :
                            (period <= PERIOD_W'(FAST_MAX_CYCLES)) ? SPEED_100M : SPEED_10M;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= '0;
      period <= PERIOD_MAX;
      dv_d <= 1'b0;
      LINK_SPEED <= SPEED_10M;
    end else begin
      dv_d <= RX_DV;
      if (rx_rise) begin
        period_cnt <= PERIOD_W'(1);
        period <= period_cnt;
      end else if (period_cnt != PERIOD_MAX) begin
        period_cnt <= period_cnt + PERIOD_W'(1);
      end
      if (en && dv_fell) begin
        LINK_SPEED <= next_speed;
      end
    end
  end

  // ****************************************************************
  // Transmit clock divider and double-rate output
  // ****************************************************************
  logic [DIV_W-1:0] div_cnt;
  logic clk_int, clk_dly;
  logic [NIBBLE_W-1:0] hi_nib, tx_d;
  logic tx_ctl, ctl_fall_val;
  wire [DIV_W-1:0] half = (TX_CLK_HALF == '0) ? DIV_RESET : TX_CLK_HALF;
  wire tick = en && (div_cnt >= half - DIV_W'(1));
  wire start_high = tick & ~clk_int;
  wire start_low = tick & clk_int;
  assign TX_TAKE = start_high;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      clk_int <= 1'b0;
      clk_dly <= 1'b0;
    end else begin
      clk_dly <= clk_int;
      if (!en || tick) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + DIV_W'(1);
      end
      if (!en) begin
        clk_int <= 1'b0;
      end else if (tick) begin
        clk_int <= ~clk_int;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_d <= '0;
      hi_nib <= '0;
      tx_ctl <= 1'b0;
      ctl_fall_val <= 1'b0;
    end else if (start_high) begin
      tx_d <= TX_DATA[NIBBLE_W-1:0];
      hi_nib <= TX_DATA[WORD_W-1:NIBBLE_W];
      tx_ctl <= TX_EN;
      ctl_fall_val <= TX_EN ^ TX_ER;
    end else if (start_low) begin
      tx_d <= hi_nib;
      tx_ctl <= ctl_fall_val;
    end else if (!en) begin
      tx_d <= '0;
      tx_ctl <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin multiplexing and management lines
  // ****************************************************************
  wire tx_clk_sel = TX_CLK_SKEW ? clk_dly : clk_int;
  assign TXD_O = en ? tx_d : GPIO_OUT[NIBBLE_W-1:0];
  assign TXD_OE = en ? {NIBBLE_W{1'b1}} : GPIO_OE[NIBBLE_W-1:0];
  assign TX_CTL_O = en ? tx_ctl : GPIO_OUT[NIBBLE_W];
  assign TX_CTL_OE = en ? 1'b1 : GPIO_OE[NIBBLE_W];
  assign TX_CLK_O = en ? tx_clk_sel : GPIO_OUT[NIBBLE_W+1];
  assign TX_CLK_OE = en ? 1'b1 : GPIO_OE[NIBBLE_W+1];
  // Receive pins read as GPIO only while the bridge is off.
  assign GPIO_IN = en ? '0 : {rxc_s2, ctl_s2, rxd_s2};

  // Open-drain: only ever pull low, the board pulls high.
  assign MDC_O = 1'b0;
  assign MDC_OE = SMI_CLK_LOW;
  assign MDIO_O = 1'b0;
  assign MDIO_OE = SMI_DATA_LOW;
  assign SMI_DATA_IN = mdio_s2;

  // The PHY keeps its receive clock quiet until the network layer frees it.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PHY_RST_N_O <= 1'b0;
    end else if (PHY_RELEASE) begin
      PHY_RST_N_O <= 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_pins_to_gpio: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    !ENABLE |-> (TXD_O == GPIO_OUT[NIBBLE_W-1:0] && TX_CLK_OE == GPIO_OE[NIBBLE_W+1]))
    else $error("Disabled bridge still drives link pins");
  a_ports_quiet: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    !ENABLE |-> (GPIO_IN == {rxc_s2, ctl_s2, rxd_s2}) ##1 (!RX_STROBE && !RX_DV))
    else $error("Disabled bridge still uses its ports");
  a_rx_byte: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (en && rx_fall) |=> (RX_STROBE && RX_DATA == {$past(rxd_s2), $past(lo_nib)}))
    else $error("Received byte not built from both edges");
  a_rx_error: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (en && rx_fall) |=> (RX_ER == ($past(ctl_r) ^ $past(ctl_s2)) && RX_DV == $past(ctl_r)))
    else $error("Receive valid or error decoded wrongly");
  a_tx_low_nibble: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    TX_TAKE |=> (tx_d == $past(TX_DATA[NIBBLE_W-1:0]) && clk_int && tx_ctl == $past(TX_EN)))
    else $error("Transmit low nibble not placed with clock high");
  a_tx_high_nib: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    start_low |=> (tx_d == $past(hi_nib) && tx_ctl == $past(ctl_fall_val) && !clk_int))
    else $error("Transmit high nibble not placed with clock low");
  a_tx_skew: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (en && TX_CLK_SKEW) |-> (TX_CLK_O == $past(clk_int)))
    else $error("Delayed transmit clock not one cycle late");
  a_strobe_split: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    TX_TAKE |-> (en && !clk_int && div_cnt == half - DIV_W'(1)))
    else $error("Transmit strobe outside its clock point");
  a_speed_update: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (en && dv_fell) |=> (LINK_SPEED == $past(next_speed)))
    else $error("Speed not updated on valid falling edge");
  a_smi_drain: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (MDIO_OE || MDC_OE) |-> (!MDIO_O && !MDC_O))
    else $error("Management line driven high");
  a_phy_held: assert property (@(posedge REF_CLK) disable iff (!rst_n)
    (!PHY_RST_N_O && !PHY_RELEASE) |=> !PHY_RST_N_O)
    else $error("PHY left reset without release");
endmodule : rgmii_ddr_sdr_bridge
`default_nettype wire

// File: rgmii_bridge_pkg.sv
// Constants shared by the link bridge between a gigabit PHY and the internal word ports.
`default_nettype none
package rgmii_bridge_pkg;
  // ****************************************************************
  // Clock rates and link timing
  // ****************************************************************
  localparam int REF_CLK_MHZ = 125;
  localparam int LINK_GIGA_MHZ = 125;
  localparam int LINK_FAST_MHZ = 25;
  // Longest sampled link clock period, in reference cycles, still taken as each speed.
  localparam int GIGA_MAX_CYCLES = (REF_CLK_MHZ + LINK_GIGA_MHZ - 1) / LINK_GIGA_MHZ;
  localparam int FAST_MAX_CYCLES = (REF_CLK_MHZ + LINK_FAST_MHZ - 1) / LINK_FAST_MHZ;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int NIBBLE_W = 4;
  localparam int WORD_W = 8;
  localparam int GPIO_W = 6;
  localparam int DIV_W = 8;
  localparam int PERIOD_W = 8;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 8'hFF;
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;
  // ****************************************************************
  // Link speeds
  // ****************************************************************
  typedef enum logic [1:0] {
    SPEED_10M,
    SPEED_100M,
    SPEED_1000M
  } speed_e;
endpackage : rgmii_bridge_pkg
`default_nettype wire

// File: phy_model.sv
// Behavioural gigabit PHY that drives the receive side of the link.
`default_nettype none
module phy_model (
  input wire logic rst_n,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_clk = 1'b0;
    rxd = 4'h5;
    rx_ctl = 1'b1;
  end
  // Sends one byte; q is a quarter of the clock period, and the clock rests low between bytes.
  task automatic send(input logic [7:0] b, input logic dv, input logic er, input realtime q);
    if (rst_n) begin
      rxd = b[3:0];
      rx_ctl = dv;
      #q rx_clk = 1'b1;
      #q rxd = b[7:4];
      rx_ctl = dv ^ er;
      #q rx_clk = 1'b0;
      #q rxd = ~b[7:4];
      rx_ctl = ~rx_ctl;
    end
  endtask : send
endmodule : phy_model
`default_nettype wire

// File: tb.sv
// Self-checking bench for the link bridge.
`default_nettype none
module tb;
  import rgmii_bridge_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, en, skew, tx_en, tx_er, smi_c, smi_d, mdio_i, rel;
  logic [7:0] half, tx_data, rx_data;
  logic [5:0] g_out, g_oe, g_in;
  logic tx_take, rx_dv, rx_er, rx_strobe, ctl_o, ctl_oe, clk_o, clk_oe, smi_in;
  logic mdc_o, mdc_oe, mdio_o, mdio_oe, phy_rst_n, rx_clk, rx_ctl;
  logic [3:0] txd_o, txd_oe, rxd;
  speed_e speed;
  int fails, n_compared, k;
  rgmii_ddr_sdr_bridge DUT (.REF_CLK(clk), .RST_N(rst_n), .ENABLE(en), .TX_CLK_HALF(half),
    .TX_CLK_SKEW(skew), .TX_DATA(tx_data), .TX_EN(tx_en), .TX_ER(tx_er), .TX_TAKE(tx_take),
    .RX_DATA(rx_data), .RX_DV(rx_dv), .RX_ER(rx_er), .RX_STROBE(rx_strobe),
    .LINK_SPEED(speed), .GPIO_OUT(g_out), .GPIO_OE(g_oe), .GPIO_IN(g_in), .TXD_O(txd_o),
    .TXD_OE(txd_oe), .TX_CTL_O(ctl_o), .TX_CTL_OE(ctl_oe), .TX_CLK_O(clk_o),
    .TX_CLK_OE(clk_oe), .RXD(rxd), .RX_CTL(rx_ctl), .RX_CLK(rx_clk), .SMI_CLK_LOW(smi_c),
    .SMI_DATA_LOW(smi_d), .SMI_DATA_IN(smi_in), .MDC_O(mdc_o), .MDC_OE(mdc_oe),
    .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .MDIO_I(mdio_i), .PHY_RELEASE(rel),
    .PHY_RST_N_O(phy_rst_n));
  phy_model PHY (.rst_n(phy_rst_n), .rx_clk(rx_clk), .rxd(rxd), .rx_ctl(rx_ctl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic t_idle();
    chk("phy_rst", 8'h00, phy_rst_n);
    chk("speed", 8'(SPEED_10M), 8'(speed));
    chk("gpio_in", 8'h15, g_in);
    g_out = 6'h2A;
    g_oe = 6'h3F;
    smi_c = 1'b1;
    mdio_i = 1'b1;
    tick(3);
    chk("pins", 8'h2A, {clk_o, ctl_o, txd_o});
    chk("pins_oe", 8'h3F, {clk_oe, ctl_oe, txd_oe});
    chk("smi", 8'h05, {mdc_o, mdio_o, mdc_oe, mdio_oe, smi_in});
    rel = 1'b1;
    tick(2);
    rel = 1'b0;
    tick(2);
    chk("phy_rst", 8'h01, phy_rst_n);
    en = 1'b1;
    tick(3);
    chk("pins_oe", 8'h3F, {clk_oe, ctl_oe, txd_oe});
    chk("gpio_in", 8'h00, g_in);
    $display("test idle done");
  endtask : t_idle
  task automatic t_rx(input logic [7:0] b, input logic dv, input logic er);
    fork
      PHY.send(b, dv, er, 31.25);
      begin
        k = 0;
        while (rx_strobe !== 1'b1 && k < 60) begin
          tick(1);
          k++;
        end
      end
    join
    chk("rx_data", b, rx_data);
    chk("rx_ctl", {6'h00, dv, er}, {6'h00, rx_dv, rx_er});
    $display("test rx %h done", b);
  endtask : t_rx
  task automatic t_speed(input realtime q, input speed_e exp);
    PHY.send(8'h11, 1'b1, 1'b0, q);
    PHY.send(8'h22, 1'b1, 1'b0, q);
    PHY.send(8'h33, 1'b0, 1'b0, q);
    tick(10);
    chk("speed", 8'(exp), 8'(speed));
    $display("test speed done");
  endtask : t_speed
  task automatic t_tx(input logic [7:0] h, input logic sk);
    half = h;
    skew = sk;
    tx_data = 8'h96;
    tx_en = 1'b1;
    tx_er = 1'b1;
    k = 0;
    @(negedge clk);
    while (tx_take !== 1'b1 && k < 600) begin
      @(negedge clk);
      k++;
    end
    tick(1);
    chk("tx_lo", {3'h0, ~sk, 4'h6}, {3'h0, clk_o, txd_o});
    chk("tx_ctl_lo", 8'h01, ctl_o);
    tick(int'(h));
    chk("tx_hi", {3'h0, sk, 4'h9}, {3'h0, clk_o, txd_o});
    chk("tx_ctl_hi", 8'h00, ctl_o);
    $display("test tx %0d done", h);
  endtask : t_tx
  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    #200000;
    fails++;
    results();
  end
  initial begin
    {rst_n, en, skew, tx_en, tx_er, smi_c, smi_d, mdio_i, rel} = '0;
    half = 8'h01;
    tx_data = 8'h00;
    g_out = 6'h00;
    g_oe = 6'h00;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(4);
    t_idle();
    t_rx(8'hA5, 1'b1, 1'b0);
    t_rx(8'h3C, 1'b1, 1'b1);
    t_rx(8'hC3, 1'b0, 1'b1);
    t_speed(9.0, SPEED_100M);
    t_speed(31.25, SPEED_10M);
    t_tx(8'h01, 1'b0);
    t_tx(8'h02, 1'b1);
    results();
  end
endmodule : tb
`default_nettype wire
